// >>> design/fpbc_pkg.sv
// constants and types shared by the flash prefetch and branch cache block
// assumes one system clock for core, fetch unit and burst flash
package fpbc_pkg;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int WORD_BYTES = 4;
	localparam int QDEPTH = 8;
	localparam int GEN_ENTRIES = 15;
	localparam int ENTRIES = GEN_ENTRIES + 1;
	localparam int VEC_IDX = GEN_ENTRIES;
	localparam int LINE = 8;
	localparam logic [31:0] VEC_ADDR_RST = 32'h0000_0018;
	localparam logic [31:0] LINE_BYTES = 32'(LINE * WORD_BYTES);

	// clock rate and highest flash fetch rate, in MHz
	localparam int CLK_MHZ = 200;
	localparam int FETCH_MAX_MHZ = 96;
	// least spacing of two flash reads, rounded up
	localparam int FETCH_GAP =
		(CLK_MHZ + FETCH_MAX_MHZ - 1) / FETCH_MAX_MHZ;

	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_RUN  = 4'h2,
		ST_LITQ = 4'h4,
		ST_LITB = 4'h8
	} fpbc_state_t;

	function automatic logic [31:0] wordOf(input logic [31:0] a);
		return {a[31:2], 2'h0};
	endfunction

	function automatic logic [31:0] nextWord(input logic [31:0] a);
		return wordOf(a) + 32'(WORD_BYTES);
	endfunction
endpackage

// >>> design/fpbc_branch_cache.sv
// branch target cache: fifteen general lines plus one vector line
// assumes the fetch unit never allocates and commits in one cycle
`timescale 1ns/1ps
`default_nettype none
module fpbc_branch_cache #(
	parameter int          ENTRIES  = fpbc_pkg::ENTRIES,
	parameter int          LINE     = fpbc_pkg::LINE,
	parameter logic [31:0] VEC_ADDR = fpbc_pkg::VEC_ADDR_RST,
	parameter int          IW       = $clog2(ENTRIES),
	parameter int          LW       = $clog2(LINE)
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          ce,
	// lookup and read
	input  wire logic [31:0]   lookAddr,
	output logic               hit,
	output logic [IW-1:0]      hitIdx,
	input  wire logic [IW-1:0] rdIdx,
	input  wire logic [LW-1:0] rdWord,
	output logic [31:0]        rdData,
	input  wire logic          touch,
	// allocate and fill
	input  wire logic          alloc,
	input  wire logic [31:0]   allocAddr,
	output logic [IW-1:0]      victim,
	input  wire logic          wrEn,
	input  wire logic [IW-1:0] wrIdx,
	input  wire logic [LW-1:0] wrWord,
	input  wire logic [31:0]   wrData,
	input  wire logic          commit
);
	localparam int GEN = ENTRIES - 1;

	logic [31:0]        tag_r [ENTRIES];
	logic [31:0]        tag_nxt [ENTRIES];
	logic [ENTRIES-1:0] vld_r;
	logic [ENTRIES-1:0] vld_nxt;
	logic [IW-1:0]      age_r [ENTRIES];
	logic [IW-1:0]      age_nxt [ENTRIES];
	logic [31:0]        mem_r [ENTRIES][LINE];
	logic [31:0]        mem_nxt [ENTRIES][LINE];
	logic [IW-1:0]      tIdx;
	logic               tEn;

	// every tag compared at once, vector line included
	always_comb begin
		hit = 1'b0;
		hitIdx = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (vld_r[i] && tag_r[i] == lookAddr) begin // RULE7
				hit = 1'b1;
				hitIdx = IW'(i);
			end
		end
	end

	assign rdData = mem_r[rdIdx][rdWord]; // RULE8

	// free line first, else the oldest; vector line never chosen
	always_comb begin
		victim = IW'(GEN - 1);
		for (int i = GEN - 1; i >= 0; i--) begin
			if (age_r[i] == IW'(GEN - 1)) begin // RULE12
				victim = IW'(i);
			end
		end
		for (int i = GEN - 1; i >= 0; i--) begin
			if (!vld_r[i]) begin // RULE9
				victim = IW'(i);
			end
		end
	end

	always_comb begin
		tag_nxt = tag_r;
		vld_nxt = vld_r;
		age_nxt = age_r;
		mem_nxt = mem_r;
		tIdx = commit ? wrIdx : hitIdx;
		tEn = commit || (touch && hit);
		if (alloc) begin
			vld_nxt[victim] = 1'b0;
			tag_nxt[victim] = allocAddr; // RULE6
		end
		if (wrEn) begin
			mem_nxt[wrIdx][wrWord] = wrData; // RULE6
		end
		if (commit) begin
			vld_nxt[wrIdx] = 1'b1;
		end
		if (tEn && tIdx != IW'(GEN)) begin
			for (int j = 0; j < GEN; j++) begin
				if (age_r[j] < age_r[tIdx]) begin // RULE12
					age_nxt[j] = age_r[j] + 1'b1;
				end
			end
			age_nxt[tIdx] = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vld_r <= '0;
			for (int i = 0; i < ENTRIES; i++) begin
				tag_r[i] <= (i == GEN) ? VEC_ADDR : 32'h0;
				age_r[i] <= IW'(i);
			end
		end else if (ce) begin
			vld_r <= vld_nxt;
			tag_r <= tag_nxt;
			age_r <= age_nxt;
		end
	end

	// line data needs no reset, valid bits guard it
	always_ff @(posedge clk) begin
		if (ce) begin
			mem_r <= mem_nxt;
		end
	end

	a_vec_kept: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		vld_r[GEN] |=> vld_r[GEN])
		else $error("vector line lost");
	a_vec_reserved: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
		alloc |-> victim != IW'(GEN) && !vld_r[GEN] == 1'b0)
		else $error("vector line chosen as victim");
	a_lru_pick: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
		alloc && (&vld_r[GEN-1:0]) |-> age_r[victim] == IW'(GEN - 1))
		else $error("victim not least recent");
	a_par_lookup: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
		hit |-> vld_r[hitIdx] && tag_r[hitIdx] == lookAddr)
		else $error("hit on wrong line");
endmodule
`default_nettype wire

// >>> design/fpbc_fetch_unit.sv
// instruction fetch front end: prefetch queue and branch target cache
// assumes core and burst flash run on clk; flash returns one word per read
//
// Notes on behaviour
// RULE1 - fetch unit sits between core instruction port and burst flash
// RULE2 - eight-word queue prefetches ahead using idle flash cycles
// RULE3 - each flash read fetches one 32-bit word, at most 96 MHz
// RULE4 - non-sequential address flushes queue; core stalls on a cache miss
// RULE5 - target address is looked up in the cache before reload
// RULE6 - cache keeps fifteen recent targets with their first eight words
// RULE7 - all fifteen tags compared in parallel, single operation
// RULE8 - hit feeds cached words while queue refetches after them
// RULE9 - sixteenth line is reserved for the interrupt vector read
// RULE10 - literal reads bypass the queue and leave it intact
// RULE11 - reserved line always holds the vector-read instruction
// RULE12 - on a miss with all lines used, least recent is replaced
`timescale 1ns/1ps
`default_nettype none
module fpbc_fetch_unit #(
	parameter int          QDEPTH   = fpbc_pkg::QDEPTH,
	parameter int          LINE     = fpbc_pkg::LINE,
	parameter logic [31:0] VEC_ADDR = fpbc_pkg::VEC_ADDR_RST
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// instruction_coupled_port, core side
	input  wire logic        coreReq,
	input  wire logic [31:0] coreAddr,
	input  wire logic        coreLiteral,
	output logic             coreValid,
	output logic [31:0]      coreData,
	// burst flash side
	output logic             flashReq,
	output logic [31:0]      flashAddr,
	input  wire logic        flashValid,
	input  wire logic [31:0] flashData
);
	localparam int PW = $clog2(QDEPTH);
	localparam int CW = $clog2(QDEPTH + 1);
	localparam int LW = $clog2(LINE);
	localparam int IW = $clog2(fpbc_pkg::ENTRIES);
	localparam logic [1:0] GAP_LAST = 2'(fpbc_pkg::FETCH_GAP - 1);

	fpbc_pkg::fpbc_state_t state_r;
	fpbc_pkg::fpbc_state_t state_nxt;

	logic [31:0]   q_r [QDEPTH];
	logic [31:0]   q_nxt [QDEPTH];
	logic [PW-1:0] rd_r;
	logic [PW-1:0] rd_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic [31:0]   qAddr_r;
	logic [31:0]   qAddr_nxt;
	logic [31:0]   fAddr_r;
	logic [31:0]   fAddr_nxt;
	logic          pend_r;
	logic          pend_nxt;
	logic          drop_r;
	logic          drop_nxt;
	logic [1:0]    gap_r;
	logic [1:0]    gap_nxt;
	logic          cAct_r;
	logic          cAct_nxt;
	logic [IW-1:0] cIdx_r;
	logic [IW-1:0] cIdx_nxt;
	logic [LW-1:0] cWord_r;
	logic [LW-1:0] cWord_nxt;
	logic [31:0]   cNext_r;
	logic [31:0]   cNext_nxt;
	logic          fillAct_r;
	logic          fillAct_nxt;
	logic [IW-1:0] fillIdx_r;
	logic [IW-1:0] fillIdx_nxt;
	logic [LW-1:0] fillCnt_r;
	logic [LW-1:0] fillCnt_nxt;
	logic          coreValid_r;
	logic          coreValid_nxt;
	logic [31:0]   coreData_r;
	logic [31:0]   coreData_nxt;
	logic          flashReq_r;
	logic          flashReq_nxt;
	logic [31:0]   flashAddr_r;
	logic [31:0]   flashAddr_nxt;

	logic          take;
	logic          arrive;
	logic          cacheSeq;
	logic          flush;
	logic          pop;
	logic          push;
	logic          pendFree;
	logic          issue;
	logic          litIssue;
	logic          allocEn;
	logic          wrEn;
	logic          commit;
	logic          hit;
	logic [IW-1:0] hitIdx;
	logic [IW-1:0] victim;
	logic [31:0]   rdData;

	assign take = coreReq && !coreValid_r;
	assign arrive = pend_r && flashValid;
	assign cacheSeq = cAct_r && coreAddr == cNext_r;

	fpbc_branch_cache #(
		.ENTRIES  (fpbc_pkg::ENTRIES),
		.LINE     (LINE),
		.VEC_ADDR (VEC_ADDR)
	) u_cache (
		.clk       (clk),
		.reset_n   (reset_n),
		.ce        (ce),
		.lookAddr  (coreAddr),
		.hit       (hit),
		.hitIdx    (hitIdx),
		.rdIdx     (cacheSeq ? cIdx_r : hitIdx),
		.rdWord    (cacheSeq ? cWord_r : LW'(0)),
		.rdData    (rdData),
		.touch     (flush),
		.alloc     (allocEn),
		.allocAddr (coreAddr),
		.victim    (victim),
		.wrEn      (wrEn),
		.wrIdx     (fillIdx_r),
		.wrWord    (fillCnt_r),
		.wrData    (flashData),
		.commit    (commit)
	);

	always_comb begin
		state_nxt = state_r;
		q_nxt = q_r;
		rd_nxt = rd_r;
		qAddr_nxt = qAddr_r;
		fAddr_nxt = fAddr_r;
		cAct_nxt = cAct_r;
		cIdx_nxt = cIdx_r;
		cWord_nxt = cWord_r;
		cNext_nxt = cNext_r;
		fillAct_nxt = fillAct_r;
		fillIdx_nxt = fillIdx_r;
		fillCnt_nxt = fillCnt_r;
		coreValid_nxt = 1'b0;
		coreData_nxt = coreData_r;
		flashReq_nxt = 1'b0;
		flashAddr_nxt = flashAddr_r;
		flush = 1'b0;
		pop = 1'b0;
		allocEn = 1'b0;
		litIssue = 1'b0;
		pendFree = !pend_r || arrive;
		case (state_r)
		fpbc_pkg::ST_BOOT: begin
			// core waits until the vector line is loaded
			state_nxt = fpbc_pkg::ST_BOOT;
		end
		fpbc_pkg::ST_RUN: begin
			if (take && coreLiteral) begin
				state_nxt = fpbc_pkg::ST_LITQ; // RULE10
			end else if (take && cacheSeq) begin
				coreValid_nxt = 1'b1; // RULE8
				coreData_nxt = rdData;
				cWord_nxt = cWord_r + 1'b1;
				cNext_nxt = fpbc_pkg::nextWord(cNext_r);
				if (cWord_r == LW'(LINE - 1)) begin
					cAct_nxt = 1'b0;
				end
			end else if (take && !cAct_r && coreAddr == qAddr_r) begin
				// sequential; stalls while the word is still on its way
				if (cnt_r != '0) begin
					pop = 1'b1; // RULE2
					coreValid_nxt = 1'b1;
					coreData_nxt = q_r[rd_r];
					rd_nxt = rd_r + 1'b1;
					qAddr_nxt = fpbc_pkg::nextWord(qAddr_r);
				end
			end else if (take) begin
				flush = 1'b1; // RULE4
				rd_nxt = '0;
				fillAct_nxt = 1'b0;
				if (hit) begin // RULE5
					coreValid_nxt = 1'b1; // RULE8
					coreData_nxt = rdData;
					cAct_nxt = 1'b1;
					cIdx_nxt = hitIdx;
					cWord_nxt = LW'(1);
					cNext_nxt = fpbc_pkg::nextWord(coreAddr);
					qAddr_nxt = fpbc_pkg::wordOf(coreAddr) +
						fpbc_pkg::LINE_BYTES; // RULE8
					fAddr_nxt = qAddr_nxt;
				end else begin
					cAct_nxt = 1'b0; // RULE4
					qAddr_nxt = coreAddr;
					fAddr_nxt = coreAddr;
					allocEn = 1'b1; // RULE12
					fillAct_nxt = 1'b1;
					fillIdx_nxt = victim;
					fillCnt_nxt = '0;
				end
			end
		end
		fpbc_pkg::ST_LITQ: begin
			// queue and its pointers are left alone for a literal
			if (pendFree && gap_r == '0) begin
				litIssue = 1'b1; // RULE10
				flashReq_nxt = 1'b1;
				flashAddr_nxt = fpbc_pkg::wordOf(coreAddr);
				state_nxt = fpbc_pkg::ST_LITB;
			end
		end
		fpbc_pkg::ST_LITB: begin
			if (arrive) begin
				coreValid_nxt = 1'b1; // RULE10
				coreData_nxt = flashData;
				state_nxt = fpbc_pkg::ST_RUN;
			end
		end
		default: begin
			state_nxt = fpbc_pkg::ST_BOOT;
		end
		endcase

		// a word answering a flushed stream is thrown away
		push = arrive && !drop_r && !flush &&
			state_r != fpbc_pkg::ST_LITB;
		if (push) begin
			q_nxt[PW'(rd_r + PW'(cnt_r))] = flashData; // RULE2
		end
		if (flush) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + CW'(push) - CW'(pop);
		end

		wrEn = push && fillAct_r; // RULE6
		commit = wrEn && fillCnt_r == LW'(LINE - 1);
		if (wrEn) begin
			fillCnt_nxt = fillCnt_r + 1'b1;
		end
		if (commit) begin
			fillAct_nxt = 1'b0;
		end
		if (commit && state_r == fpbc_pkg::ST_BOOT) begin
			state_nxt = fpbc_pkg::ST_RUN; // RULE11
		end

		// look ahead only while a free slot is left for the answer
		issue = pendFree && gap_r == '0 && !litIssue &&
			cnt_nxt < CW'(QDEPTH) &&
			(state_r == fpbc_pkg::ST_BOOT ||
			 state_r == fpbc_pkg::ST_RUN);
		if (issue) begin
			flashReq_nxt = 1'b1; // RULE1
			flashAddr_nxt = fpbc_pkg::wordOf(fAddr_nxt); // RULE3
			fAddr_nxt = fpbc_pkg::nextWord(fAddr_nxt);
		end

		if (issue || litIssue) begin
			gap_nxt = GAP_LAST; // RULE3
			pend_nxt = 1'b1;
		end else begin
			gap_nxt = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
			pend_nxt = pend_r && !arrive;
		end
		if (flush && pend_r && !flashValid) begin
			drop_nxt = 1'b1; // RULE4
		end else if (arrive) begin
			drop_nxt = 1'b0;
		end else begin
			drop_nxt = drop_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r <= fpbc_pkg::ST_BOOT;
			rd_r <= '0;
			cnt_r <= '0;
			qAddr_r <= VEC_ADDR;
			fAddr_r <= VEC_ADDR;
			pend_r <= 1'b0;
			drop_r <= 1'b0;
			gap_r <= '0;
			cAct_r <= 1'b0;
			cIdx_r <= '0;
			cWord_r <= '0;
			cNext_r <= '0;
			fillAct_r <= 1'b1;
			fillIdx_r <= IW'(fpbc_pkg::VEC_IDX);
			fillCnt_r <= '0;
			coreValid_r <= 1'b0;
			coreData_r <= '0;
			flashReq_r <= 1'b0;
			flashAddr_r <= '0;
		end else if (ce) begin
			state_r <= state_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			qAddr_r <= qAddr_nxt;
			fAddr_r <= fAddr_nxt;
			pend_r <= pend_nxt;
			drop_r <= drop_nxt;
			gap_r <= gap_nxt;
			cAct_r <= cAct_nxt;
			cIdx_r <= cIdx_nxt;
			cWord_r <= cWord_nxt;
			cNext_r <= cNext_nxt;
			fillAct_r <= fillAct_nxt;
			fillIdx_r <= fillIdx_nxt;
			fillCnt_r <= fillCnt_nxt;
			coreValid_r <= coreValid_nxt;
			coreData_r <= coreData_nxt;
			flashReq_r <= flashReq_nxt;
			flashAddr_r <= flashAddr_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			q_r <= q_nxt;
		end
	end

	assign coreValid = coreValid_r;
	assign coreData = coreData_r;
	assign flashReq = flashReq_r;
	assign flashAddr = flashAddr_r;

	sequence s_hit;
		flush && hit && ce;
	endsequence
	sequence s_miss;
		flush && !hit && ce;
	endsequence

	a_queue_bound: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
		cnt_r <= CW'(QDEPTH))
		else $error("queue overfilled");
	a_word_align: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		flashReq_r |-> flashAddr_r[1:0] == 2'h0 && pend_r)
		else $error("flash read not one word");
	a_fetch_rate: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		flashReq_r && ce |=> !flashReq_r [*2])
		else $error("flash reads too close");
	a_flush_empty: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		s_miss |=> cnt_r == '0 && fAddr_r != qAddr_r || pend_r)
		else $error("queue not flushed on branch");
	a_miss_stall: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		s_miss |=> !coreValid_r [*3])
		else $error("miss answered too early");
	a_hit_fast: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
		s_hit |=> coreValid_r && cAct_r &&
			qAddr_r == fpbc_pkg::wordOf($past(coreAddr)) + 32'h20)
		else $error("hit not served from cache");
	a_lit_keep: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
		state_r == fpbc_pkg::ST_LITB && arrive && ce |=>
			coreValid_r && coreData_r == $past(flashData) &&
			cnt_r == $past(cnt_r) && qAddr_r == $past(qAddr_r))
		else $error("literal disturbed the queue");
endmodule
`default_nettype wire

// >>> verif/fpbc_flash_model.sv
// burst flash model: one word per read, delay set by the bench
// assumes the fetch unit's clk; ce drops only with no read in flight
`timescale 1ns/1ps
`default_nettype none
module fpbc_flash_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// read port
	input  wire logic        flashReq,
	input  wire logic [31:0] flashAddr,
	output logic             flashValid,
	output logic [31:0]      flashData,
	// answer delay and count of broken read rules
	input  wire logic [2:0]  lat,
	output logic [7:0]       faults
);
	logic [2:0]  left;
	logic [31:0] addr;
	logic [31:0] gap;
	logic        busy;

	function automatic logic [31:0] memf(input logic [31:0] a);
		return {~a[15:0], a[15:0]} ^ 32'h00a5_0000;
	endfunction

	always @(posedge clk) begin
		if (!reset_n) begin
			busy       <= 1'b0;
			flashValid <= 1'b0;
			flashData  <= 32'h0;
			faults     <= 8'h0;
			gap        <= 32'h3;
		end else begin
			flashValid <= 1'b0;
			// released bus inverts the old word each cycle, so it returns every other cycle
			flashData  <= ~flashData;
			gap        <= gap + 32'h1;
			if (busy) begin
				left <= left - 3'h1;
				if (left == 3'h1) begin
					busy       <= 1'b0;
					flashValid <= 1'b1;
					flashData  <= memf(addr);
				end
			end
			if (flashReq) begin
				if (busy || gap < 32'h3 || flashAddr[1:0] != 2'h0)
					faults <= faults + 8'h1;
				busy <= 1'b1;
				left <= lat;
				addr <= flashAddr;
				gap  <= 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/flash_prefetch_branch_cache_tb_top.sv
// self-checking bench for the fetch unit with a burst flash model
// assumes ce drops only while no flash read is in flight; random delay
`timescale 1ns/1ps
`default_nettype none
module flash_prefetch_branch_cache_tb_top;
	logic        clk;
	logic        reset_n;
	logic        ce;
	logic        coreReq;
	logic [31:0] coreAddr;
	logic        coreLiteral;
	logic        coreValid;
	logic [31:0] coreData;
	logic        flashReq;
	logic [31:0] flashAddr;
	logic        flashValid;
	logic [31:0] flashData;
	logic [2:0]  lat;
	logic [7:0]  faults;
	logic [31:0] expQ[$];
	logic [31:0] lit;
	int          err_count;
	int          n_tests;
	int          cycles;
	int          nRd;
	int          n;
	int          seed;

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	fpbc_fetch_unit u_dut (
		.clk(clk), .reset_n(reset_n), .ce(ce),
		.coreReq(coreReq), .coreAddr(coreAddr), .coreLiteral(coreLiteral),
		.coreValid(coreValid), .coreData(coreData),
		.flashReq(flashReq), .flashAddr(flashAddr),
		.flashValid(flashValid), .flashData(flashData)
	);

	fpbc_flash_model u_flash (
		.clk(clk), .reset_n(reset_n), .flashReq(flashReq),
		.flashAddr(flashAddr), .flashValid(flashValid),
		.flashData(flashData), .lat(lat), .faults(faults)
	);

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// request stays up until the answer edge; n counts edges from launch
	task automatic fetch(input logic [31:0] a, input logic l);
		coreReq     <= 1'b1;
		coreAddr    <= a;
		coreLiteral <= l;
		expQ.push_back(u_flash.memf(a));
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (coreValid !== 1'b1 && n < 300);
		if (coreValid !== 1'b1)
			check("answerWait", 32'(n), 32'h0);
	endtask

	task automatic idle(input int k);
		coreReq <= 1'b0;
		repeat (k) @(posedge clk);
	endtask

	// a prompt answer is seen two edges after launch
	task automatic seq(input logic [31:0] a, input int cnt, input bit hit);
		for (int i = 0; i < cnt; i++) begin
			fetch(a + 32'(4 * i), 1'b0);
			if (hit)
				check("latency", 32'(n), 32'h2);
		end
	endtask

	always @(posedge clk) begin
		if (coreValid === 1'b1) begin
			if (expQ.size() == 0)
				check("extraAnswer", 32'h1, 32'h0);
			else
				check("coreData", coreData, expQ.pop_front());
		end
		if (reset_n === 1'b1 && flashReq === 1'b1 && nRd < 8) begin
			check("bootAddr", flashAddr,
				fpbc_pkg::VEC_ADDR_RST + 32'(4 * nRd));
			nRd++;
		end
	end

	// flash delay 1..4 cycles, slow and prompt answers mixed
	always @(posedge clk) begin
		cycles++;
		lat <= 3'(32'h1 + (32'($random(seed)) & 32'h3));
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	initial begin
		seed = 32'hc06c1c67;
		reset_n = 1'b0;
		coreReq = 1'b0;
		coreAddr = 32'h0;
		coreLiteral = 1'b0;
		ce = 1'b1;
		err_count = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		idle(100);
		seq(fpbc_pkg::VEC_ADDR_RST, 8, 1'b1);
		idle(2);
		fetch(32'h100, 1'b0);
		check("missStall", {31'h0, n > 2}, 32'h1);
		idle(40);
		seq(32'h104, 7, 1'b1);
		idle(60);
		// frozen unit must neither answer nor read; queue is full here
		ce          <= 1'b0;
		coreReq     <= 1'b1;
		coreAddr    <= 32'h120;
		coreLiteral <= 1'b0;
		repeat (6) @(posedge clk);
		check("frozen", {30'h0, coreValid, flashReq}, 32'h0);
		ce <= 1'b1;
		seq(32'h120, 1, 1'b1);
		lit = 32'h8000 | (32'($random(seed)) & 32'h7ffc);
		fetch(lit, 1'b1);
		seq(32'h124, 1, 1'b1);
		idle(2);
		seq(32'h100, 8, 1'b1);
		seq(32'h120, 1, 1'b0);
		// sixteen new targets overflow the fifteen general lines
		for (int i = 0; i < 16; i++) begin
			idle(2);
			seq(32'h1000 + 32'(i) * 32'h100, 8, 1'b0);
		end
		idle(20);
		seq(32'h1f00, 1, 1'b1);
		idle(2);
		seq(32'h1800, 1, 1'b1);
		idle(2);
		fetch(32'h1000, 1'b0);
		check("lruEvicted", {31'h0, n > 2}, 32'h1);
		idle(2);
		seq(fpbc_pkg::VEC_ADDR_RST, 1, 1'b1);
		idle(20);
		check("flashFaults", {24'h0, faults}, 32'h0);
		check("pending", 32'(expQ.size()), 32'h0);
		results();
	end
endmodule
`default_nettype wire
